/* hw/tpio_pkg.sv */
/*
 package for the three-port parallel io block: register indices, field widths, reset values.
 assumes a byte-wide register port with one-cycle read latency.
*/
// How it works
// - direction one drives latch, zero makes input
// - reset clears all direction bits to input
// - data latches keep contents through reset
// - first port read: latch if output, pin if input
// - latch writes always land, whatever direction
// - first port pullup enable pulls input pins that are not keyboard-enabled
// - pullup drops automatically when pin is output
// - third port has per-pin input pullups too
// - keyboard enables make first-port pins interrupts
// - analog channel select overrides second-port pin
// - second port eight bits, no pullups
// - second port read: latch or pin per direction
// - third port seven bits, latch, direction, pullup
// - third port read: latch or pin per direction
package tpio_pkg;
   localparam int ADDR_W = 4;
   localparam int A_W = 8;
   localparam int B_W = 8;
   localparam int C_W = 7;
   localparam logic [ADDR_W-1:0] OFS_A_DATA = 4'h0;
   localparam logic [ADDR_W-1:0] OFS_B_DATA = 4'h1;
   localparam logic [ADDR_W-1:0] OFS_C_DATA = 4'h2;
   localparam logic [ADDR_W-1:0] OFS_A_DIR = 4'h4;
   localparam logic [ADDR_W-1:0] OFS_B_DIR = 4'h5;
   localparam logic [ADDR_W-1:0] OFS_C_DIR = 4'h6;
   localparam logic [ADDR_W-1:0] OFS_A_PUE = 4'h8;
   localparam logic [ADDR_W-1:0] OFS_C_PUE = 4'h9;
   localparam logic [ADDR_W-1:0] OFS_KBD_CTL = 4'hA;
   localparam logic [ADDR_W-1:0] OFS_ADC_SEL = 4'hB;
   localparam logic [7:0] DIR_RST = 8'h00;
   localparam logic [7:0] PUE_RST = 8'h00;
   localparam logic [7:0] KBD_RST = 8'h00;
   localparam logic [7:0] ADC_SEL_RST = 8'h00;
   localparam int ADC_EN_BIT = 7;
   localparam int ADC_CH_W = 3;
endpackage : tpio_pkg

/* hw/tpio_pin.sv */
/*
 one pin's output buffer and pullup control.
 assumes pad logic outside resolves the wire from enables.
*/
module tpio_pin (
   input wire logic dir,
   input wire logic latch,
   input wire logic pue,
   input wire logic force_in,
   output logic out,
   output logic oe,
   output logic pull_en
);
   always_comb begin
      out = latch;
      oe = dir & ~force_in;
      pull_en = pue & ~dir & ~force_in;
   end
endmodule : tpio_pin

/* hw/tpio_top.sv */
/*
 three-port parallel io: data latches, direction and pullup registers, pin muxing.
 assumes pin inputs synchronous to clock and a register master per the plain port.
*/
// The address-and-strobe port was chosen for this implementation.
module tpio_top (
   input wire logic clock,
   input wire logic sys_rst,
   input wire logic [tpio_pkg::ADDR_W-1:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   input wire logic [tpio_pkg::A_W-1:0] port_a_in,
   output logic [tpio_pkg::A_W-1:0] port_a_out,
   output logic [tpio_pkg::A_W-1:0] port_a_oe,
   output logic [tpio_pkg::A_W-1:0] port_a_pull_en,
   input wire logic [tpio_pkg::B_W-1:0] port_b_in,
   output logic [tpio_pkg::B_W-1:0] port_b_out,
   output logic [tpio_pkg::B_W-1:0] port_b_oe,
   output logic [tpio_pkg::B_W-1:0] analog_channel_inputs,
   input wire logic [tpio_pkg::C_W-1:0] port_c_in,
   output logic [tpio_pkg::C_W-1:0] port_c_out,
   output logic [tpio_pkg::C_W-1:0] port_c_oe,
   output logic [tpio_pkg::C_W-1:0] port_c_pull_en,
   output logic [tpio_pkg::A_W-1:0] keyboard_interrupt_inputs
);
   import tpio_pkg::*;

   logic [A_W-1:0] a_lat_r, a_lat_nxt;
   logic [B_W-1:0] b_lat_r, b_lat_nxt;
   logic [C_W-1:0] c_lat_r, c_lat_nxt;
   logic [A_W-1:0] a_dir_r, a_dir_nxt;
   logic [B_W-1:0] b_dir_r, b_dir_nxt;
   logic [C_W-1:0] c_dir_r, c_dir_nxt;
   logic [A_W-1:0] a_pue_r, a_pue_nxt;
   logic [C_W-1:0] c_pue_r, c_pue_nxt;
   logic [A_W-1:0] kbd_en_r, kbd_en_nxt;
   logic [7:0] adc_sel_r, adc_sel_nxt;
   logic [7:0] rdata_r, rdata_nxt;
   logic [B_W-1:0] b_force;
   logic [A_W-1:0] a_pin_rd;
   logic [B_W-1:0] b_pin_rd;
   logic [C_W-1:0] c_pin_rd;

   // data latches: no reset term at all
   always_comb begin
      a_lat_nxt = a_lat_r;
      b_lat_nxt = b_lat_r;
      c_lat_nxt = c_lat_r;
      if (reg_wr) begin
         unique case (reg_addr)
            OFS_A_DATA: a_lat_nxt = reg_wdata;
            OFS_B_DATA: b_lat_nxt = reg_wdata;
            OFS_C_DATA: c_lat_nxt = reg_wdata[C_W-1:0];
            default: ;
         endcase
      end
   end

   always_ff @(posedge clock) begin
      a_lat_r <= a_lat_nxt;
      b_lat_r <= b_lat_nxt;
      c_lat_r <= c_lat_nxt;
   end

   // control registers
   always_comb begin
      a_dir_nxt = a_dir_r;
      b_dir_nxt = b_dir_r;
      c_dir_nxt = c_dir_r;
      a_pue_nxt = a_pue_r;
      c_pue_nxt = c_pue_r;
      kbd_en_nxt = kbd_en_r;
      adc_sel_nxt = adc_sel_r;
      if (reg_wr) begin
         unique case (reg_addr)
            OFS_A_DIR: a_dir_nxt = reg_wdata;
            OFS_B_DIR: b_dir_nxt = reg_wdata;
            OFS_C_DIR: c_dir_nxt = reg_wdata[C_W-1:0];
            OFS_A_PUE: a_pue_nxt = reg_wdata;
            OFS_C_PUE: c_pue_nxt = reg_wdata[C_W-1:0];
            OFS_KBD_CTL: kbd_en_nxt = reg_wdata;
            OFS_ADC_SEL: adc_sel_nxt = reg_wdata;
            default: ;
         endcase
      end
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         a_dir_r <= DIR_RST[A_W-1:0];
         b_dir_r <= DIR_RST[B_W-1:0];
         c_dir_r <= DIR_RST[C_W-1:0];
         a_pue_r <= PUE_RST[A_W-1:0];
         c_pue_r <= PUE_RST[C_W-1:0];
         kbd_en_r <= KBD_RST[A_W-1:0];
         adc_sel_r <= ADC_SEL_RST;
      end else begin
         a_dir_r <= a_dir_nxt;
         b_dir_r <= b_dir_nxt;
         c_dir_r <= c_dir_nxt;
         a_pue_r <= a_pue_nxt;
         c_pue_r <= c_pue_nxt;
         kbd_en_r <= kbd_en_nxt;
         adc_sel_r <= adc_sel_nxt;
      end
   end

   // analog channel select: one-hot force on the second port
   always_comb begin
      b_force = '0;
      if (adc_sel_r[ADC_EN_BIT]) begin
         b_force[adc_sel_r[ADC_CH_W-1:0]] = 1'b1;
      end
   end

   assign analog_channel_inputs = b_force;
   assign keyboard_interrupt_inputs = kbd_en_r & port_a_in;

   genvar gi;
   generate
      for (gi = 0; gi < A_W; gi++) begin : g_a
         tpio_pin u_pin (
            .dir(a_dir_r[gi]),
            .latch(a_lat_r[gi]),
            .pue(a_pue_r[gi]),
            .force_in(kbd_en_r[gi]),
            .out(port_a_out[gi]),
            .oe(port_a_oe[gi]),
            .pull_en(port_a_pull_en[gi])
         );
      end
      for (gi = 0; gi < B_W; gi++) begin : g_b
         tpio_pin u_pin (
            .dir(b_dir_r[gi]),
            .latch(b_lat_r[gi]),
            .pue(1'b0),
            .force_in(b_force[gi]),
            .out(port_b_out[gi]),
            .oe(port_b_oe[gi]),
            .pull_en()
         );
      end
      for (gi = 0; gi < C_W; gi++) begin : g_c
         tpio_pin u_pin (
            .dir(c_dir_r[gi]),
            .latch(c_lat_r[gi]),
            .pue(c_pue_r[gi]),
            .force_in(1'b0),
            .out(port_c_out[gi]),
            .oe(port_c_oe[gi]),
            .pull_en(port_c_pull_en[gi])
         );
      end
   endgenerate

   // per-bit read select: latch for outputs, pin for inputs
   always_comb begin
      a_pin_rd = (a_dir_r & a_lat_r) | (~a_dir_r & port_a_in);
      b_pin_rd = (b_dir_r & b_lat_r) | (~b_dir_r & port_b_in);
      c_pin_rd = (c_dir_r & c_lat_r) | (~c_dir_r & port_c_in);
   end

   always_comb begin
      rdata_nxt = 8'h00;
      if (reg_rd) begin
         unique case (reg_addr)
            OFS_A_DATA: rdata_nxt = a_pin_rd;
            OFS_B_DATA: rdata_nxt = b_pin_rd;
            OFS_C_DATA: rdata_nxt = {1'b0, c_pin_rd};
            OFS_A_DIR: rdata_nxt = a_dir_r;
            OFS_B_DIR: rdata_nxt = b_dir_r;
            OFS_C_DIR: rdata_nxt = {1'b0, c_dir_r};
            OFS_A_PUE: rdata_nxt = a_pue_r;
            OFS_C_PUE: rdata_nxt = {1'b0, c_pue_r};
            OFS_KBD_CTL: rdata_nxt = kbd_en_r;
            OFS_ADC_SEL: rdata_nxt = adc_sel_r;
            default: rdata_nxt = 8'h00;
         endcase
      end
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         rdata_r <= 8'h00;
      end else begin
         rdata_r <= rdata_nxt;
      end
   end

   assign reg_rdata = rdata_r;
endmodule : tpio_top

/* sim/tpio_asserts.sv */
/*
 port-level checks for the three-port parallel io block.
 assumes it is bound into tpio_top and sees only its ports.
*/
module tpio_asserts (
   input wire logic clock,
   input wire logic sys_rst,
   input wire logic [tpio_pkg::ADDR_W-1:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_rdata,
   input wire logic [tpio_pkg::A_W-1:0] port_a_in,
   input wire logic [tpio_pkg::A_W-1:0] port_a_oe,
   input wire logic [tpio_pkg::A_W-1:0] port_a_pull_en,
   input wire logic [tpio_pkg::B_W-1:0] port_b_out,
   input wire logic [tpio_pkg::B_W-1:0] port_b_oe,
   input wire logic [tpio_pkg::B_W-1:0] analog_channel_inputs,
   input wire logic [tpio_pkg::C_W-1:0] port_c_in,
   input wire logic [tpio_pkg::C_W-1:0] port_c_out,
   input wire logic [tpio_pkg::C_W-1:0] port_c_oe,
   input wire logic [tpio_pkg::C_W-1:0] port_c_pull_en,
   input wire logic [tpio_pkg::A_W-1:0] keyboard_interrupt_inputs
);
   timeunit 1ns;
   timeprecision 1ps;
   import tpio_pkg::*;
   wire logic [C_W-1:0] c_vis = (port_c_oe & port_c_out) | (~port_c_oe & port_c_in);
   default clocking @(posedge clock); endclocking
   default disable iff (sys_rst);
   sequence c_rd_s;
      reg_rd && reg_addr == OFS_C_DATA;
   endsequence
   a_dir_reset: assert property ($past(sys_rst) |->
      !(|{port_a_oe, port_b_oe, port_c_oe, port_a_pull_en, port_c_pull_en}))
      else $error("pin enabled right after reset");
   a_rd_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
      else $error("read data outside its cycle");
   a_pull_drop: assert property (((port_a_pull_en & port_a_oe) == 8'h00)
      && ((port_c_pull_en & port_c_oe) == 7'h00)) else $error("pullup on a driven pin");
   a_dir_take: assert property (reg_wr && reg_addr == OFS_C_DIR |=>
      port_c_oe == $past(reg_wdata[6:0])) else $error("direction write not applied");
   a_pue_take: assert property (reg_wr && reg_addr == OFS_C_PUE |=>
      port_c_pull_en == ($past(reg_wdata[6:0]) & ~port_c_oe)) else $error("pullup mismatch");
   a_latch_take: assert property (reg_wr && reg_addr == OFS_B_DATA |=>
      port_b_out == $past(reg_wdata)) else $error("latch write lost");
   a_c_read: assert property (c_rd_s |=> reg_rdata == {1'b0, $past(c_vis)})
      else $error("third port read wrong");
   a_kbd_gate: assert property (reg_wr && reg_addr == OFS_KBD_CTL |=>
      keyboard_interrupt_inputs == (port_a_in & $past(reg_wdata))) else $error("key gate");
   a_adc_pick: assert property (reg_wr && reg_addr == OFS_ADC_SEL && reg_wdata[7] |=>
      analog_channel_inputs == (8'h01 << $past(reg_wdata[2:0]))
      && (port_b_oe & analog_channel_inputs) == 8'h00) else $error("analog pin not forced");
endmodule : tpio_asserts

bind tpio_top tpio_asserts u_chk (
   .clock(clock),
   .sys_rst(sys_rst),
   .reg_addr(reg_addr),
   .reg_wdata(reg_wdata),
   .reg_wr(reg_wr),
   .reg_rd(reg_rd),
   .reg_rdata(reg_rdata),
   .port_a_in(port_a_in),
   .port_a_oe(port_a_oe),
   .port_a_pull_en(port_a_pull_en),
   .port_b_out(port_b_out),
   .port_b_oe(port_b_oe),
   .analog_channel_inputs(analog_channel_inputs),
   .port_c_in(port_c_in),
   .port_c_out(port_c_out),
   .port_c_oe(port_c_oe),
   .port_c_pull_en(port_c_pull_en),
   .keyboard_interrupt_inputs(keyboard_interrupt_inputs)
);

/* sim/tpio_board.sv */
/*
 board model of one port's pins.
 assumes the bench sets the level of undriven, unpulled pins.
*/
module tpio_board #(
   parameter int W = 8
) (
   input wire logic [W-1:0] o,
   input wire logic [W-1:0] e,
   input wire logic [W-1:0] p,
   input wire logic [W-1:0] x,
   output logic [W-1:0] i
);
   timeunit 1ns;
   timeprecision 1ps;
   // the board leaves pulled pins floating, so the pullup decides them
   assign i = (e & o) | (~e & (p | x));
endmodule : tpio_board

/* sim/test_three_port_parallel_io.sv */
/*
 self-checking bench for tpio_top.
 assumes tpio_board models the pins and tpio_asserts is bound.
*/
module test_three_port_parallel_io;
   timeunit 1ns;
   timeprecision 1ps;
   import tpio_pkg::*;
   logic clock = 1'b0, sys_rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, rd_d = 1'b0;
   logic [3:0] reg_addr = 4'h0;
   logic [7:0] reg_wdata = 8'h00, reg_rdata, l, d, p, a_o, a_e, a_p, a_i, b_o, b_e, b_i;
   logic [7:0] ext [3] = '{8'h00, 8'h00, 8'h00};
   logic [6:0] c_o, c_e, c_p, c_i;
   logic [7:0] exp_q [$];
   logic [7:0] pin_exp;
   int num_errors = 0, comparisons = 0;
   // second address of the pullup table is unmapped: the second port has none
   localparam logic [3:0] DAT [3] = '{OFS_A_DATA, OFS_B_DATA, OFS_C_DATA};
   localparam logic [3:0] DIR [3] = '{OFS_A_DIR, OFS_B_DIR, OFS_C_DIR};
   localparam logic [3:0] PUE [3] = '{OFS_A_PUE, 4'h3, OFS_C_PUE};
   localparam logic [7:0] MSK [3] = '{8'hFF, 8'hFF, 8'h7F};
   localparam logic [7:0] HASP [3] = '{8'hFF, 8'h00, 8'h7F};
   always #4 clock = ~clock;
   tpio_top DUT (.clock(clock), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .port_a_in(a_i), .port_a_out(a_o),
      .port_a_oe(a_e), .port_a_pull_en(a_p), .port_b_in(b_i), .port_b_out(b_o), .port_b_oe(b_e),
      .analog_channel_inputs(), .port_c_in(c_i), .port_c_out(c_o), .port_c_oe(c_e),
      .port_c_pull_en(c_p), .keyboard_interrupt_inputs());
   tpio_board #(.W(8)) brd_a (.o(a_o), .e(a_e), .p(a_p), .x(ext[0]), .i(a_i));
   tpio_board #(.W(8)) brd_b (.o(b_o), .e(b_e), .p(8'h00), .x(ext[1]), .i(b_i));
   tpio_board #(.W(7)) brd_c (.o(c_o), .e(c_e), .p(c_p), .x(ext[2][6:0]), .i(c_i));
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      comparisons++;
      if (got !== exp) begin
         num_errors++;
         $display("ERROR %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task automatic wr(input logic [3:0] a, input logic [7:0] v);
      reg_wr <= 1'b1;
      reg_rd <= 1'b0;
      reg_addr <= a;
      reg_wdata <= v;
      @(posedge clock);
   endtask : wr
   task automatic rd(input logic [3:0] a, input logic [7:0] e);
      reg_rd <= 1'b1;
      reg_wr <= 1'b0;
      reg_addr <= a;
      exp_q.push_back(e);
      @(posedge clock);
   endtask : rd
   task automatic end_of_test;
      if (num_errors == 0 && comparisons > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : end_of_test
   // read data stand in the cycle after the strobe, so check at the next edge
   always @(posedge clock) begin
      if (rd_d) chk(reg_rdata, exp_q.pop_front());
      rd_d <= reg_rd && !sys_rst;
   end
   initial begin
      repeat (2000) @(posedge clock);
      num_errors++;
      end_of_test();
   end
   initial begin
      void'($urandom(32'hA9898EBD));
      repeat (2) @(posedge clock);
      sys_rst <= 1'b0;
      for (int k = 0; k < 3; k++) begin
         rd(DIR[k], 8'h00);
         rd(PUE[k], 8'h00);
      end
      repeat (12) for (int k = 0; k < 3; k++) begin
         l = 8'($urandom);
         d = 8'($urandom);
         p = 8'($urandom);
         ext[k] <= 8'($urandom);
         wr(DAT[k], ~l);
         wr(DIR[k], d);
         wr(PUE[k], p);
         wr(DAT[k], l);
         rd(DIR[k], d & MSK[k]);
         pin_exp = MSK[k] & ((l & d) | (~d & ((p & HASP[k]) | ext[k])));
         rd(DAT[k], pin_exp);
      end
      wr(OFS_A_DATA, 8'h5A);
      reg_wr <= 1'b0;
      sys_rst <= 1'b1;
      repeat (2) @(posedge clock);
      sys_rst <= 1'b0;
      // board ties the third-port pins low, so the two upper input pins read zero
      ext[2] <= 8'h00;
      rd(OFS_A_DIR, 8'h00);
      wr(OFS_A_DIR, 8'hFF);
      rd(OFS_A_DATA, 8'h5A);
      wr(OFS_C_DIR, 8'h1F);
      rd(OFS_C_DATA, l & 8'h1F);
      p = 8'($urandom);
      wr(OFS_KBD_CTL, p);
      rd(OFS_KBD_CTL, p);
      for (int k = 0; k < 8; k++) wr(OFS_ADC_SEL, 8'h80 | 8'(k));
      rd(OFS_ADC_SEL, 8'h87);
      rd(OFS_B_DATA, ext[1]);
      reg_wr <= 1'b0;
      reg_rd <= 1'b0;
      repeat (2) @(posedge clock);
      end_of_test();
   end
endmodule : test_three_port_parallel_io
